// >>> logic/dbp_pkg.sv
/*
 * Shared constants for the single-wire debug port: character codes,
 * instruction encoding, control-space map, key signatures and the
 * host's own register map.
 * Assumes both ends of the link are built from the same package.
 */
package dbp_pkg;
    // bit timing, in clock cycles and bit periods
    localparam logic [7:0] BIT_DIV = 8'h04;
    localparam logic [7:0] FRAME_BITS = 8'h0C;
    localparam logic [7:0] IBD_BITS = 8'h02;
    localparam logic [7:0] GT_BASE = 8'h02;

    // characters
    localparam logic [7:0] SYNC_CHAR = 8'h55;
    localparam logic [7:0] ACK_CHAR = 8'h40;

    // instruction opcodes, bits 7:5 of the instruction byte
    localparam logic [2:0] OP_DIRECT_LOAD = 3'h0;
    localparam logic [2:0] OP_DIRECT_STORE = 3'h1;
    localparam logic [2:0] OP_INDIRECT_LOAD = 3'h2;
    localparam logic [2:0] OP_INDIRECT_STORE = 3'h3;
    localparam logic [2:0] OP_CS_LOAD = 3'h4;
    localparam logic [2:0] OP_REPEAT = 3'h5;
    localparam logic [2:0] OP_CS_STORE = 3'h6;
    localparam logic [2:0] OP_KEY = 3'h7;

    // pointer modes, bits 3:2 of an indirect instruction
    localparam logic [1:0] PTR_PLAIN = 2'h0;
    localparam logic [1:0] PTR_POSTINC = 2'h1;
    localparam logic [1:0] PTR_REG = 2'h2;

    // key instruction: bit 2 asks for the info block, bits 1:0 the size
    localparam int KEY_SIB_BIT = 2;
    localparam logic [1:0] KEY_SIZE_8 = 2'h0;
    localparam logic [1:0] KEY_SIZE_16 = 2'h1;

    // control-space indices, bits 3:0 of a control-space instruction
    localparam logic [3:0] CS_CTRL_A = 4'h0;
    localparam logic [3:0] CS_KEY_STATUS = 4'h1;
    localparam logic [3:0] CS_RESET_REQ = 4'h2;
    localparam logic [3:0] CS_SYS_STATUS = 4'h3;
    localparam logic [3:0] CS_BOOT_CRC = 4'h4;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam int CTRL_INTERBYTE_DELAY_ENABLE_BIT = 7;
    localparam int CTRL_PORT_DIS_BIT = 2;
    localparam int KEY_ERASE_BIT = 3;
    localparam int KEY_NVM_BIT = 4;
    localparam int KEY_UROW_BIT = 5;
    localparam int SYS_LOCK_BIT = 0;
    localparam int SYS_UROW_BIT = 2;
    localparam int SYS_NVM_BIT = 3;
    localparam logic [7:0] RST_SIG = 8'hA5;

    // key signatures, least significant byte sent first
    localparam logic [63:0] SIG_ERASE = 64'h4E564D4572617365;
    localparam logic [63:0] SIG_NVM = 64'h4E564D50726F6720;
    localparam logic [63:0] SIG_UROW = 64'h4E564D5573267465;
    localparam logic [7:0] SIB_RSVD = 8'h20;

    // transmit sources
    localparam logic [1:0] TXK_ACK = 2'h0;
    localparam logic [1:0] TXK_CS = 2'h1;
    localparam logic [1:0] TXK_MEM = 2'h2;
    localparam logic [1:0] TXK_SIB = 2'h3;

    // host register map
    localparam logic [11:0] HOST_TX_ADDR = 12'h000;
    localparam logic [11:0] HOST_RX_ADDR = 12'h004;
    localparam logic [11:0] HOST_STAT_ADDR = 12'h008;
    localparam int TX_BRK_BIT = 8;
    localparam int RX_VALID_BIT = 8;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_RXV_BIT = 1;
    localparam int ST_OVR_BIT = 2;
    localparam int ST_REFUSED_BIT = 3;
endpackage : dbp_pkg

// >>> logic/dbp_link_if.sv
/*
 * Byte-level view of the single-wire half-duplex link.
 * Assumes one clock shared by both ends; each valid is a one-cycle
 * pulse marking the end of a whole character frame.
 */
`timescale 1ns/1ns
interface dbp_link_if;
    logic h2d_valid;
    logic [7:0] h2d_data;
    logic h2d_brk;
    logic d2h_valid;
    logic [7:0] d2h_data;

    modport device(input h2d_valid, input h2d_data, input h2d_brk,
                   output d2h_valid, output d2h_data);
    modport host(output h2d_valid, output h2d_data, output h2d_brk,
                 input d2h_valid, input d2h_data);
endinterface : dbp_link_if

// >>> logic/dbp_device.sv
/*
 * Device end of the debug port: instruction layer with repeat,
 * control space, keys, info block readout, guard time and
 * inter-byte delay, plus a small flip-flop data space.
 * Assumes the link interface delivers whole characters on CLK_IN.
 */
`timescale 1ns/1ns
// Notes on behaviour
// - control-space store returns no acknowledge
// - repeated iterations skip sync and instruction
// - debugger never repeats the repeat instruction
// - repeated instruction runs count plus one times
// - only a break aborts a repeat
// - repeated indirect store acknowledges each block
// - repeated indirect load streams, guard once
// - debugger uses post-increment when repeating indirect; the bench repeats indirect in PTR_REG mode
// - direct access resends address every iteration
// - keys are 64 bits, info block 128
// - size field sets frames; key unanswered
// - info block follows the current guard time
// - boot checksum status readable while locked
// - inter-byte delay adds two idle bits
// - guard time on direction change, and again before each repeated CS load or info block
// - info block always readable, ASCII only
// - sixteen bytes full block, eight family only
// - fixed byte layout of the info block
// - signatures least byte first, exact match
// - each key cleared by its own events
// - programming enables depend on lock and ready
// - sync character raises an event
// - debugger releases reset request by writing zero
module dbp_device #(
    parameter int MEM_DEPTH = 16,
    parameter logic [7:0] BIT_DIV = dbp_pkg::BIT_DIV,
    parameter logic [55:0] FAMILY_IDENTIFIER = 56'h4445_4D4F_5041_52, // arbitrary
    parameter logic [23:0] NVM_REV = 24'h503A31, // arbitrary
    parameter logic [23:0] DBG_REV = 24'h443A31, // arbitrary
    parameter logic [7:0] OSC_FREQ = 8'h33 // arbitrary
)(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // link
    dbp_link_if.device LINK,
    // system status
    input wire logic LOCK_IN,
    input wire logic NVM_READY_IN,
    input wire logic UROW_READY_IN,
    input wire logic PROG_DONE_IN,
    input wire logic [7:0] BOOT_CRC_IN,
    // system controls
    output logic SYS_RESET_REQ_OUT,
    output logic ERASE_KEY_OUT,
    output logic NVM_PROG_EN_OUT,
    output logic UROW_PROG_EN_OUT,
    output logic SYNC_EVENT_OUT
);
    localparam int AW = $clog2(MEM_DEPTH);
    if (MEM_DEPTH < 2 || MEM_DEPTH > 256 || (1 << AW) != MEM_DEPTH) begin : g_chk
        $error("MEM_DEPTH must be a power of two from 2 to 256");
    end
    if (BIT_DIV == 8'h00) begin : g_chk_div
        $error("BIT_DIV must be nonzero");
    end

    typedef enum logic [7:0] {
        S_SYNC = 8'h01, S_INSTR = 8'h02, S_RPT = 8'h04, S_ADDR = 8'h08,
        S_DATA = 8'h10, S_CSDATA = 8'h20, S_KEY = 8'h40, S_TX = 8'h80
    } dbp_dev_state_e;

    dbp_dev_state_e state, next_state, start_st;
    logic [7:0] div_cnt, instr, addr, ptr, rpt, ctrl_a, rst_req, tx_wait, cs_rd, tx_byte;
    logic [7:0] mem [MEM_DEPTH];
    logic [63:0] key_sr;
    logic [3:0] key_cnt, tx_idx;
    logic [8:0] tx_left, start_len;
    logic [1:0] tx_kind, start_kind;
    logic tx_to_data, erase_key, nvm_key, urow_key;
    logic enter_tx, enter_to_data;
    logic [1:0] enter_kind;
    logic [8:0] enter_len;

    wire bit_tick = (div_cnt == BIT_DIV - 8'h01);
    wire rx = LINK.h2d_valid & ~LINK.h2d_brk;
    wire [7:0] rxd = LINK.h2d_data;
    wire [7:0] ins = (state == S_INSTR) ? rxd : instr;
    wire [2:0] op = ins[7:5];
    wire [1:0] pm = ins[3:2];
    wire interbyte_delay_enable = ctrl_a[dbp_pkg::CTRL_INTERBYTE_DELAY_ENABLE_BIT];
    wire [7:0] guard_bits = dbp_pkg::GT_BASE << ctrl_a[1:0];
    wire tx_stream = (instr[7:5] == dbp_pkg::OP_INDIRECT_LOAD);
    wire tx_fire = (state == S_TX) && bit_tick && (tx_wait == 8'h01);
    wire tx_last = tx_fire && (tx_left == 9'h001);
    wire key16 = (instr[1:0] == dbp_pkg::KEY_SIZE_16);
    wire key_last = (key_cnt == (key16 ? 4'hF : 4'h7));
    wire [63:0] key_full = {rxd, key_sr[63:8]};
    wire key_in = (state == S_KEY) && rx && key_last && !key16;
    wire ptr_wr = (instr[7:5] == dbp_pkg::OP_INDIRECT_STORE) && (instr[3:2] == dbp_pkg::PTR_REG);
    wire post_inc = (instr[3:2] == dbp_pkg::PTR_POSTINC);
    wire [7:0] mem_idx = (instr[7:5] == dbp_pkg::OP_DIRECT_LOAD ||
                          instr[7:5] == dbp_pkg::OP_DIRECT_STORE) ? addr : ptr;
    wire [127:0] sib_vec = {OSC_FREQ, dbp_pkg::SIB_RSVD, DBG_REV, NVM_REV,
                            dbp_pkg::SIB_RSVD, FAMILY_IDENTIFIER};
    wire iter_done = (state == S_CSDATA && rx)
        || (state == S_KEY && rx && key_last)
        || (tx_last && !tx_to_data && !tx_stream);
    wire begin_iter = (state == S_INSTR && rx) || (iter_done && rpt != 8'h00);

    // first step of an iteration, from the instruction byte
    always_comb
    begin
        start_st = S_SYNC;
        start_kind = dbp_pkg::TXK_ACK;
        start_len = 9'h001;
        unique case (op)
            dbp_pkg::OP_DIRECT_LOAD, dbp_pkg::OP_DIRECT_STORE: start_st = S_ADDR;
            dbp_pkg::OP_INDIRECT_STORE: start_st = S_DATA;
            dbp_pkg::OP_INDIRECT_LOAD:
            begin
                start_st = S_TX;
                start_kind = dbp_pkg::TXK_MEM;
                start_len = {1'b0, rpt} + 9'h001;
            end
            dbp_pkg::OP_CS_LOAD:
            begin
                start_st = S_TX;
                start_kind = dbp_pkg::TXK_CS;
            end
            dbp_pkg::OP_REPEAT: start_st = S_RPT;
            dbp_pkg::OP_CS_STORE: start_st = S_CSDATA;
            dbp_pkg::OP_KEY:
            begin
                if (ins[dbp_pkg::KEY_SIB_BIT])
                begin
                    start_st = S_TX;
                    start_kind = dbp_pkg::TXK_SIB;
                    start_len = (ins[1:0] == dbp_pkg::KEY_SIZE_16) ? 9'h010 : 9'h008;
                end
                else
                begin
                    start_st = S_KEY;
                end
            end
        endcase
    end

    always_comb
    begin
        enter_tx = 1'b0;
        enter_kind = start_kind;
        enter_len = start_len;
        enter_to_data = 1'b0;
        if (begin_iter)
        begin
            enter_tx = (start_st == S_TX);
        end
        else if ((state == S_ADDR || state == S_DATA) && rx)
        begin
            enter_tx = 1'b1;
            enter_len = 9'h001;
            enter_kind = (state == S_ADDR && op == dbp_pkg::OP_DIRECT_LOAD) ?
                         dbp_pkg::TXK_MEM : dbp_pkg::TXK_ACK;
            enter_to_data = (state == S_ADDR && op == dbp_pkg::OP_DIRECT_STORE);
        end
    end

    always_comb
    begin
        next_state = state;
        if (LINK.h2d_brk)
        begin
            next_state = S_SYNC;
        end
        else if (begin_iter)
        begin
            next_state = start_st;
        end
        else if (iter_done)
        begin
            next_state = S_SYNC;
        end
        else
        begin
            unique case (state)
                S_SYNC: if (rx && rxd == dbp_pkg::SYNC_CHAR) next_state = S_INSTR;
                S_RPT: if (rx) next_state = S_SYNC;
                S_ADDR, S_DATA: if (rx) next_state = S_TX;
                S_TX: if (tx_last) next_state = tx_to_data ? S_DATA : S_SYNC;
                default: next_state = state;
            endcase
        end
    end

    always_comb
    begin
        unique case (instr[3:0])
            dbp_pkg::CS_CTRL_A: cs_rd = ctrl_a;
            dbp_pkg::CS_KEY_STATUS: cs_rd = 8'(({2'b00, urow_key, nvm_key, erase_key}) << 3);
            dbp_pkg::CS_RESET_REQ: cs_rd = rst_req;
            dbp_pkg::CS_SYS_STATUS: cs_rd = {4'h0, NVM_READY_IN, UROW_READY_IN, 1'b0, LOCK_IN};
            dbp_pkg::CS_BOOT_CRC: cs_rd = BOOT_CRC_IN;
            default: cs_rd = 8'h00;
        endcase
    end

    always_comb
    begin
        unique case (tx_kind)
            dbp_pkg::TXK_ACK: tx_byte = dbp_pkg::ACK_CHAR;
            dbp_pkg::TXK_CS: tx_byte = cs_rd;
            dbp_pkg::TXK_MEM: tx_byte = (instr[3:2] == dbp_pkg::PTR_REG && tx_stream) ? ptr :
                                        (LOCK_IN ? 8'h00 : mem[mem_idx[AW-1:0]]);
            dbp_pkg::TXK_SIB: tx_byte = sib_vec[{tx_idx, 3'b000} +: 8];
        endcase
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN || bit_tick) div_cnt <= 8'h00;
        else div_cnt <= div_cnt + 8'h01;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN) state <= S_SYNC;
        else state <= next_state;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN || LINK.h2d_brk) rpt <= 8'h00;
        else if (state == S_RPT && rx) rpt <= rxd;
        else if (iter_done && rpt != 8'h00) rpt <= rpt - 8'h01;
        else if (tx_last && tx_stream) rpt <= 8'h00;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            instr <= 8'h00;
            addr <= 8'h00;
        end
        else
        begin
            if (state == S_INSTR && rx) instr <= rxd;
            if (state == S_ADDR && rx) addr <= rxd;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN) ptr <= 8'h00;
        else if (state == S_DATA && rx && ptr_wr) ptr <= rxd;
        else if (state == S_DATA && rx && post_inc && instr[7:5] == dbp_pkg::OP_INDIRECT_STORE)
            ptr <= ptr + 8'h01;
        else if (tx_fire && tx_stream && post_inc) ptr <= ptr + 8'h01;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (state == S_DATA && rx && !ptr_wr && !LOCK_IN) mem[mem_idx[AW-1:0]] <= rxd;
    end

    // transmit timing: guard on entry, frame plus optional idle bits after
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            tx_wait <= 8'h00;
            tx_left <= 9'h000;
            tx_kind <= dbp_pkg::TXK_ACK;
            tx_idx <= 4'h0;
            tx_to_data <= 1'b0;
        end
        else if (enter_tx)
        begin
            tx_wait <= guard_bits + dbp_pkg::FRAME_BITS;
            tx_left <= enter_len;
            tx_kind <= enter_kind;
            tx_idx <= 4'h0;
            tx_to_data <= enter_to_data;
        end
        else if (tx_fire)
        begin
            tx_wait <= dbp_pkg::FRAME_BITS + (interbyte_delay_enable ? dbp_pkg::IBD_BITS : 8'h00);
            tx_left <= tx_left - 9'h001;
            tx_idx <= tx_idx + 4'h1;
        end
        else if (state == S_TX && bit_tick)
        begin
            tx_wait <= tx_wait - 8'h01;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN || state != S_KEY) key_cnt <= 4'h0;
        else if (rx) key_cnt <= key_cnt + 4'h1;
        if (state == S_KEY && rx) key_sr <= key_full;
    end

    // control space writes and key status; a set wins over a clear
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            ctrl_a <= dbp_pkg::CTRL_A_RESET;
            rst_req <= 8'h00;
            erase_key <= 1'b0;
            nvm_key <= 1'b0;
            urow_key <= 1'b0;
        end
        else
        begin
            if (state == S_CSDATA && rx)
            begin
                if (instr[3:0] == dbp_pkg::CS_CTRL_A) ctrl_a <= rxd;
                if (instr[3:0] == dbp_pkg::CS_RESET_REQ) rst_req <= rxd;
                if (instr[3:0] == dbp_pkg::CS_CTRL_A && rxd[dbp_pkg::CTRL_PORT_DIS_BIT])
                    erase_key <= 1'b0;
                if (instr[3:0] == dbp_pkg::CS_KEY_STATUS && rxd[dbp_pkg::KEY_UROW_BIT])
                    urow_key <= 1'b0;
            end
            if (PROG_DONE_IN) nvm_key <= 1'b0;
            // any other value leaves all three alone
            if (key_in && key_full == dbp_pkg::SIG_ERASE) erase_key <= 1'b1;
            if (key_in && key_full == dbp_pkg::SIG_NVM) nvm_key <= 1'b1;
            if (key_in && key_full == dbp_pkg::SIG_UROW) urow_key <= 1'b1;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            LINK.d2h_valid <= 1'b0;
            LINK.d2h_data <= 8'h00;
            SYS_RESET_REQ_OUT <= 1'b0;
            ERASE_KEY_OUT <= 1'b0;
            NVM_PROG_EN_OUT <= 1'b0;
            UROW_PROG_EN_OUT <= 1'b0;
            SYNC_EVENT_OUT <= 1'b0;
        end
        else
        begin
            LINK.d2h_valid <= tx_fire;
            if (tx_fire) LINK.d2h_data <= tx_byte;
            SYS_RESET_REQ_OUT <= (rst_req == dbp_pkg::RST_SIG);
            ERASE_KEY_OUT <= erase_key;
            NVM_PROG_EN_OUT <= nvm_key && !LOCK_IN && NVM_READY_IN;
            UROW_PROG_EN_OUT <= urow_key && LOCK_IN && UROW_READY_IN;
            SYNC_EVENT_OUT <= (state == S_SYNC) && rx && (rxd == dbp_pkg::SYNC_CHAR);
        end
    end
endmodule : dbp_device

// >>> logic/dbp_host.sv
/*
 * Debugger end of the debug port: an APB slave through which software
 * sends characters or a break and collects answers.
 * Assumes APB signals synchronous to CLK_IN; one character in flight.
 */
`timescale 1ns/1ns
module dbp_host #(
    parameter logic [7:0] BIT_DIV = dbp_pkg::BIT_DIV
)(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // register bus
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // link
    dbp_link_if.host LINK
);
    if (BIT_DIV == 8'h00) begin : g_chk
        $error("BIT_DIV must be nonzero");
    end

    logic [7:0] div_cnt, tx_byte, tx_bits, rx_byte;
    logic tx_busy, tx_brk, rx_valid, overrun, refused, after_sync, last_rpt;

    wire bit_tick = (div_cnt == BIT_DIV - 8'h01);
    wire setup = PSEL_IN && !PENABLE_IN;
    wire access = PSEL_IN && PENABLE_IN;
    wire hit_tx = (PADDR_IN == dbp_pkg::HOST_TX_ADDR);
    wire hit_rx = (PADDR_IN == dbp_pkg::HOST_RX_ADDR);
    wire hit_st = (PADDR_IN == dbp_pkg::HOST_STAT_ADDR);
    wire wr_tx = access && PWRITE_IN && hit_tx;
    wire wr_st = access && PWRITE_IN && hit_st;
    wire pop = access && !PWRITE_IN && hit_rx;
    wire wr_brk = PWDATA_IN[dbp_pkg::TX_BRK_BIT];
    wire rpt_twice = after_sync && last_rpt && !wr_brk
                     && (PWDATA_IN[7:5] == dbp_pkg::OP_REPEAT);
    wire take = wr_tx && !tx_busy && !rpt_twice;
    wire tx_done = tx_busy && bit_tick && (tx_bits == 8'h01);
    wire rx_in = LINK.d2h_valid;
    wire [31:0] rd_mux = hit_rx ? {23'h0, rx_valid, rx_byte} :
                         hit_st ? {28'h0, refused, overrun, rx_valid, tx_busy} : 32'h0;

    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = access && !(hit_tx || hit_rx || hit_st);

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN || bit_tick) div_cnt <= 8'h00;
        else div_cnt <= div_cnt + 8'h01;
    end

    // one character frame per accepted write, then a pulse on the link
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            tx_busy <= 1'b0;
            tx_brk <= 1'b0;
            tx_byte <= 8'h00;
            tx_bits <= 8'h00;
            after_sync <= 1'b0;
            last_rpt <= 1'b0;
        end
        else if (take)
        begin
            tx_busy <= 1'b1;
            tx_brk <= wr_brk;
            tx_byte <= PWDATA_IN[7:0];
            tx_bits <= dbp_pkg::FRAME_BITS;
            after_sync <= !wr_brk && (PWDATA_IN[7:0] == dbp_pkg::SYNC_CHAR);
            if (wr_brk) last_rpt <= 1'b0;
            else if (after_sync) last_rpt <= (PWDATA_IN[7:5] == dbp_pkg::OP_REPEAT);
        end
        else if (tx_done)
        begin
            tx_busy <= 1'b0;
        end
        else if (tx_busy && bit_tick)
        begin
            tx_bits <= tx_bits - 8'h01;
        end
    end

    // received byte holding register; arrival wins over pop and clear
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
            overrun <= 1'b0;
            refused <= 1'b0;
        end
        else
        begin
            if (rx_in) rx_byte <= LINK.d2h_data;
            rx_valid <= rx_in || (rx_valid && !pop);
            overrun <= (rx_in && rx_valid && !pop)
                       || (overrun && !(wr_st && PWDATA_IN[dbp_pkg::ST_OVR_BIT]));
            refused <= (wr_tx && !take)
                       || (refused && !(wr_st && PWDATA_IN[dbp_pkg::ST_REFUSED_BIT]));
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            PRDATA_OUT <= 32'h0;
            LINK.h2d_valid <= 1'b0;
            LINK.h2d_brk <= 1'b0;
            LINK.h2d_data <= 8'h00;
        end
        else
        begin
            if (setup) PRDATA_OUT <= rd_mux;
            LINK.h2d_valid <= tx_done && !tx_brk;
            LINK.h2d_brk <= tx_done && tx_brk;
            if (tx_done) LINK.h2d_data <= tx_byte;
        end
    end
endmodule : dbp_host

// >>> sim/dbp_link_props.sv
/*
 * Assertions on the byte-level debug link between host and device.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ns
module dbp_link_props (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // link
    input wire logic h2d_valid,
    input wire logic [7:0] h2d_data,
    input wire logic h2d_brk,
    input wire logic d2h_valid,
    input wire logic [7:0] d2h_data
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    logic after_sync;
    logic st_pend;
    logic [9:0] mute;
    wire logic is_instr = h2d_valid && after_sync;
    wire logic [2:0] op = h2d_data[7:5];
    // mute spans the unanswered store or key and ends before the earliest next answer
    always_ff @(posedge CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            after_sync <= 1'b0;
            st_pend <= 1'b0;
            mute <= 10'h000;
        end
        else
        begin
            if (h2d_valid) after_sync <= h2d_data == dbp_pkg::SYNC_CHAR;
            if (h2d_valid) st_pend <= is_instr && op == dbp_pkg::OP_INDIRECT_STORE;
            if (is_instr && op == dbp_pkg::OP_CS_STORE) mute <= 10'h0B4;
            else if (is_instr && op == dbp_pkg::OP_KEY && !h2d_data[2]) mute <= 10'h1F4;
            else if (mute != 10'h000) mute <= mute - 10'h001;
        end
    end
    chk_data_hold: assert property (!d2h_valid |-> $stable(d2h_data))
        else $error("device data moved between characters");
    chk_turn_gap: assert property (h2d_valid |=> !d2h_valid [*8])
        else $error("answer without guard time");
    chk_stream_gap: assert property (d2h_valid |=> !d2h_valid [*8])
        else $error("device characters too close");
    chk_mute_window: assert property (mute != 10'h000 |-> !d2h_valid)
        else $error("answer to a store or key");
    chk_load_answer: assert property (is_instr && (op == dbp_pkg::OP_CS_LOAD
        || op == dbp_pkg::OP_KEY && h2d_data[2]) |-> ##[50:130] d2h_valid)
        else $error("load answer missing");
    chk_store_ack: assert property (st_pend && h2d_valid
        |-> ##[50:130] d2h_valid && d2h_data == dbp_pkg::ACK_CHAR)
        else $error("store acknowledge missing");
    chk_brk_alone: assert property (h2d_brk |-> !h2d_valid ##1 !h2d_brk)
        else $error("break malformed");
    chk_host_pulse: assert property (h2d_valid |=> !h2d_valid)
        else $error("host character pulse too long");
endmodule : dbp_link_props

// >>> sim/testbench.sv
/*
 * Self-checking bench: host and device ends joined by the link.
 * Assumes software reaches the host over APB on the same clock.
 */
`timescale 1ns/1ns
module testbench;
    localparam logic [127:0] SIBV = {8'h4B, dbp_pkg::SIB_RSVD, 24'h443130, 24'h4E3130,
        dbp_pkg::SIB_RSVD, 56'h4E4F5445534C41}; // arbitrary ascii
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, sev;
    logic lock = 0, nvm_rdy = 1, urow_rdy = 1, done = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [7:0] crc = 8'h00, ptr;
    wire logic [2:0] en;
    int bad_count = 0, n_tests = 0, cyc = 0, last = 0, gap = 0, n, ns = 0;
    logic [63:0] sig [3] = '{dbp_pkg::SIG_ERASE, dbp_pkg::SIG_NVM, dbp_pkg::SIG_UROW};
    dbp_link_if link();
    dbp_host i_dbp_host (.CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LINK(link.host));
    dbp_device #(.FAMILY_IDENTIFIER(SIBV[55:0]), .NVM_REV(SIBV[87:64]), .DBG_REV(SIBV[111:88]),
        .OSC_FREQ(SIBV[127:120])) i_dbp_device (.CLK_IN(clk), .RSTN_IN(rstn),
        .LINK(link.device), .LOCK_IN(lock), .NVM_READY_IN(nvm_rdy), .UROW_READY_IN(urow_rdy),
        .PROG_DONE_IN(done), .BOOT_CRC_IN(crc), .SYS_RESET_REQ_OUT(), .ERASE_KEY_OUT(en[0]),
        .NVM_PROG_EN_OUT(en[1]), .UROW_PROG_EN_OUT(en[2]), .SYNC_EVENT_OUT(sev));
    dbp_link_props i_dbp_link_props (.CLK_IN(clk), .RSTN_IN(rstn), .h2d_valid(link.h2d_valid),
        .h2d_data(link.h2d_data), .h2d_brk(link.h2d_brk), .d2h_valid(link.d2h_valid),
        .d2h_data(link.d2h_data));
    initial forever #25 clk = ~clk;
    // cycles between device characters, and the hang limit
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (link.d2h_valid) gap <= cyc - last;
        if (link.d2h_valid) last <= cyc;
        if (sev) ns <= ns + 1;
        if (cyc == 40000) bad_count = bad_count + 1;
        if (cyc == 40000) stop_test();
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) $display("Error at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp) bad_count++;
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic send(input logic [8:0] b);
        apb(1, dbp_pkg::HOST_TX_ADDR, {23'h0, b});
        do apb(0, dbp_pkg::HOST_STAT_ADDR, 0); while (r[dbp_pkg::ST_BUSY_BIT] !== 1'b0);
    endtask : send
    task automatic tx(input logic [7:0] q[$]);
        foreach (q[i]) send({1'b0, q[i]});
    endtask : tx
    task automatic rx(input logic [7:0] exp, input int g);
        do apb(0, dbp_pkg::HOST_STAT_ADDR, 0); while (r[dbp_pkg::ST_RXV_BIT] !== 1'b1);
        apb(0, dbp_pkg::HOST_RX_ADDR, 0);
        chk(r[7:0], exp);
        if (g != 0) chk(8'(gap), 8'(g));
    endtask : rx
    task automatic key(input logic [63:0] s);
        tx('{8'h55, 8'hE0});
        for (int i = 0; i < 8; i++) send({1'b0, s[8*i+:8]});
    endtask : key
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    initial
    begin
        crc <= 8'($urandom(23444));
        repeat (6) @(posedge clk);
        rstn <= 1;
        lock <= 1;
        tx('{8'h55, 8'h84});
        rx(crc, 0);
        apb(0, 12'h00C, 0);
        chk({7'h0, e}, 8'h01);
        tx('{8'h55, 8'hE5});
        for (int i = 0; i < 16; i++) rx(SIBV[8*i+:8], i ? 48 : 0);
        tx('{8'h55, 8'hE4});
        for (int i = 0; i < 8; i++) rx(SIBV[8*i+:8], i ? 48 : 0);
        key(dbp_pkg::SIG_ERASE ^ (64'h01 << 8 * ($urandom % 8)));
        tx('{8'h55, 8'h81});
        rx(8'h00, 0);
        for (int k = 0; k < 3; k++)
        begin
            lock <= k == 2;
            key(sig[k]);
            tx('{8'h55, 8'h81});
            rx(8'h08 << k, 0);
            chk({5'h0, en}, 8'h01 << k);
            lock <= k != 2;
            apb(0, dbp_pkg::HOST_STAT_ADDR, 0);
            chk({5'h0, en}, k ? 8'h00 : 8'h01);
            done <= k == 1;
            if (k != 1) tx('{8'h55, k ? 8'hC1 : 8'hC0, k ? 8'h20 : 8'h04});
            else @(posedge clk);
            done <= 0;
            tx('{8'h55, 8'h81});
            rx(8'h00, 0);
            chk({5'h0, en}, 8'h00);
        end
        lock <= 0;
        tx('{8'h55, 8'hC0, 8'h80});
        for (int j = 0; j < 2; j++)
        begin
            ptr = 8'h80 | 8'($urandom);
            n = j ? 1 + $urandom % 4 : 0;
            tx('{8'h55, 8'h68, ptr});
            rx(dbp_pkg::ACK_CHAR, 0);
            tx('{8'h55, 8'hA0, 8'(n), 8'h55, 8'h48});
            for (int i = 0; i <= n; i++) rx(ptr, i ? 56 : 0);
        end
        tx('{8'h55, 8'hA0, 8'h03, 8'h55, 8'h68, ptr ^ 8'h01});
        rx(dbp_pkg::ACK_CHAR, 0);
        send(9'h100);
        n = ns;
        tx('{8'h55, 8'h48});
        chk(8'(ns - n), 8'h01);
        rx(ptr ^ 8'h01, 0);
        stop_test();
    end
endmodule : testbench
